// *** inc/sslink_pkg.sv ***
// Shared constants, register map and types of the synchronous serial line interface
package sslink_pkg;

   // ***************************************************
   // Register map (byte offsets, one 32-bit word each)
   // ***************************************************
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_SYNC = 8'h04;
   localparam logic [7:0] ADDR_TXD  = 8'h08;
   localparam logic [7:0] ADDR_RXD  = 8'h0C;
   localparam logic [7:0] ADDR_ST   = 8'h10;
   localparam logic [7:0] ADDR_MASK = 8'h14;

   // Control fields
   localparam int CTRL_W    = 11;
   localparam int CTRL_RXIE = 0;
   localparam int CTRL_TXIE = 1;
   localparam int CTRL_STIE = 2;
   localparam int CTRL_STRIP = 3;
   localparam int CTRL_IDLE = 4;
   localparam int CTRL_HDX  = 5;
   localparam int CTRL_DTR  = 6;
   localparam int CTRL_RXEN = 7;
   localparam int CTRL_LEN  = 8;
   localparam logic [CTRL_W-1:0] CTRL_RST = 11'h000;

   // Status events (sticky) and live status bits
   localparam int NUM_EV  = 5;
   localparam int ST_RX   = 0;
   localparam int ST_TX   = 1;
   localparam int ST_CAR  = 2;
   localparam int ST_OVR  = 3;
   localparam int ST_RING = 4;
   localparam int ST_RSYNC = 8;
   localparam int ST_CARL = 9;
   localparam int ST_CTS  = 10;
   localparam int ST_RTS  = 11;
   localparam int BUF_FULL = 15;

   // Character sizes
   localparam int MAXW = 12;
   localparam logic [MAXW-1:0] ALL_ONES = 12'hFFF;

   // Line timing
   localparam int BAUD_MAX = 50000;
   localparam int CLK_NS   = 10;
   localparam int BIT_NS   = 1000000000 / BAUD_MAX;
   localparam int BIT_CYC  = BIT_NS / CLK_NS;
   localparam logic [1:0] RTS_DROP_EDGES = 2'h2;

   typedef enum logic [1:0] {
      RX_HUNT = 2'b00,
      RX_ONE  = 2'b01,
      RX_LOCK = 2'b10
   } rx_state_e;

   typedef enum logic [1:0] {
      TX_OFF   = 2'b00,
      TX_WAIT  = 2'b01,
      TX_RUN   = 2'b10,
      TX_DRAIN = 2'b11
   } tx_state_e;

   // Length code to bits; codes 3..5 give long characters only when built in
   function automatic logic [3:0] char_len(input logic [2:0] code, input logic ext);
      case (code)
         3'h0:    char_len = 4'h6;
         3'h1:    char_len = 4'h7;
         3'h3:    char_len = ext ? 4'hA : 4'h8;
         3'h4:    char_len = ext ? 4'hB : 4'h8;
         3'h5:    char_len = ext ? 4'hC : 4'h8;
         default: char_len = 4'h8;
      endcase
   endfunction

endpackage

// *** src/sync_tx_serializer.sv ***
// Transmit shift register: loads a character and shifts it out LSB first
`timescale 1ns/1ps
module sync_tx_serializer #(
   parameter int W = 12
) (
   input  wire logic         core_clk_i,
   input  wire logic         rst_i,
   input  wire logic         bit_en_i,
   input  wire logic         load_i,
   input  wire logic [W-1:0] data_i,
   input  wire logic [3:0]   len_i,
   output logic              line_o,
   output logic              empty_o
);

   logic [W-1:0] sr;
   logic [3:0]   cnt;

   // Count holds bits left including the one on the line; mark when done
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         sr     <= '0;
         cnt    <= 4'h0;
         line_o <= 1'b1;
      end else if (bit_en_i) begin
         if (load_i) begin
            line_o <= data_i[0];
            sr     <= data_i >> 1;
            cnt    <= len_i;
         end else if (cnt != 4'h0) begin
            line_o <= (cnt > 4'h1) ? sr[0] : 1'b1;
            sr     <= sr >> 1;
            cnt    <= cnt - 4'h1;
         end
      end
   end

   // Reload wanted at the next bit edge so characters follow back to back
   assign empty_o = (cnt <= 4'h1);

   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);

   chk_load_first_bit: assert property (bit_en_i && load_i |=> line_o == $past(data_i[0]))
      else $error("first bit not driven on load");
   chk_mark_after_end: assert property (bit_en_i && !load_i && cnt == 4'h1 |=> line_o)
      else $error("line not at mark after last bit");

endmodule

// *** src/sync_rx_deserializer.sv ***
// Receive shift register with two-character sync hunt and character framing
`timescale 1ns/1ps
module sync_rx_deserializer #(
   parameter int W = 12
) (
   input  wire logic         core_clk_i,
   input  wire logic         rst_i,
   input  wire logic         clear_i,
   input  wire logic         bit_en_i,
   input  wire logic         line_i,
   input  wire logic [3:0]   len_i,
   input  wire logic [W-1:0] sync_i,
   output logic [W-1:0]      char_o,
   output logic              stb_o,
   output logic              synced_o
);

   sslink_pkg::rx_state_e state;
   logic [W-1:0] sr;
   logic [W-1:0] next_sr;
   logic [W-1:0] next_win;
   logic [3:0]   cnt;
   logic         match;
   logic         last;

   // First bit received ends up rightmost: shift in at the top, align down
   assign next_sr  = {line_i, sr[W-1:1]};
   assign next_win = next_sr >> (4'hC - len_i);
   assign match    = (next_win == (sync_i & (sslink_pkg::ALL_ONES >> (4'hC - len_i))));
   assign last     = (cnt == len_i - 4'h1);

   // Hunt bit by bit, then demand a second sync one character later
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state    <= sslink_pkg::RX_HUNT;
         sr       <= '0;
         cnt      <= 4'h0;
         char_o   <= '0;
         stb_o    <= 1'b0;
         synced_o <= 1'b0;
      end else if (clear_i) begin
         state    <= sslink_pkg::RX_HUNT;
         cnt      <= 4'h0;
         stb_o    <= 1'b0;
         synced_o <= 1'b0;
      end else begin
         stb_o <= 1'b0;
         if (bit_en_i) begin
            sr <= next_sr;
            case (state)
               sslink_pkg::RX_HUNT: begin
                  cnt <= 4'h0;
                  if (match) begin
                     state <= sslink_pkg::RX_ONE;
                  end
               end
               sslink_pkg::RX_ONE: begin
                  cnt <= last ? 4'h0 : cnt + 4'h1;
                  if (last) begin
                     state    <= match ? sslink_pkg::RX_LOCK : sslink_pkg::RX_HUNT;
                     synced_o <= match;
                  end
               end
               sslink_pkg::RX_LOCK: begin
                  cnt <= last ? 4'h0 : cnt + 4'h1;
                  if (last) begin
                     char_o <= next_win;
                     stb_o  <= 1'b1;
                  end
               end
               default: state <= sslink_pkg::RX_HUNT;
            endcase
         end
      end
   end

   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);

   chk_lock_two_syncs: assert property ($rose(synced_o) |-> $past(state) == sslink_pkg::RX_ONE)
      else $error("sync flag set without two sync characters");
   chk_clear_drops: assert property (clear_i |=> !synced_o && !stb_o)
      else $error("receiver still active while cleared");

endmodule

// *** src/sync_serial_line_interface.sv ***
// Synchronous serial line interface: Wishbone registers, tx/rx control, modem leads
`timescale 1ns/1ps
// Notes on behaviour
// - Character length is 6, 7 or 8 bits, chosen by software, both directions.
// - A build option adds 10, 11 and 12 bit characters.
// - Software sets the sync character, character size and terminal ready output; send request is driven by the transmit sequencer.
// - Sync removal and transmit idle fill have separate software enables.
// - When idling, the sync register is sent instead of the data buffer.
// - Transmit and receive have separate interrupt requests; priority is fixed by build.
// - Both paths are double buffered and interrupt when service is needed.
// - Full or half duplex, chosen by software.
// - Serial in to parallel, parallel out to serial, and drive modem leads.
// - Serial logic works at line rates up to 50,000 baud.
// - Ring raises a status interrupt, only while status interrupts are enabled.
// - Auto answer works through ring interrupt and terminal ready output.
// - Receiver needs two consecutive sync characters before it assembles characters.
// - A character arriving before the previous one is read sets overrun.
// - Without idle fill and no refresh, line goes to mark and send request drops.
// - Status interrupts share the transmit request; carrier change, overrun, ring cause them.
module sync_serial_line_interface #(
   parameter bit EXT_LEN = 1'b0
) (
   input  wire logic        core_clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        line_clk_i,
   input  wire logic        rxd_i,
   input  wire logic        cts_i,
   input  wire logic        carrier_i,
   input  wire logic        ring_i,
   output logic             txd_o,
   output logic             rts_o,
   output logic             dtr_o,
   output logic             rx_irq_o,
   output logic             tx_irq_o,
   output logic             irq_o
);

   localparam int NPIN = 5;
   localparam int W    = sslink_pkg::MAXW;

   logic [sslink_pkg::CTRL_W-1:0] ctrl;
   logic [W-1:0]      sync_chr;
   logic [W-1:0]      sync_m;
   logic [W-1:0]      tx_hold;
   logic [W-1:0]      rx_hold;
   logic [W-1:0]      rx_char;
   logic [W-1:0]      tx_word;
   logic              hold_full;
   logic              rx_full;
   logic [sslink_pkg::NUM_EV-1:0] st;
   logic [sslink_pkg::NUM_EV-1:0] mask;
   logic [sslink_pkg::NUM_EV-1:0] ev;
   logic [sslink_pkg::NUM_EV-1:0] clr;
   logic [NPIN-1:0]   pin_raw;
   logic [NPIN-1:0]   pin_m;
   logic [NPIN-1:0]   pin_s;
   logic [NPIN-1:0]   pin_q;
   logic [3:0]        len;
   logic [15:0]       wmask;
   logic [15:0]       wd;
   logic [31:0]       rdata;
   logic              wb_req;
   logic              wr;
   logic              rd;
   logic              rx_en;
   logic              tx_en;
   logic              car_chg;
   logic              ring_rise;
   logic              cts_s;
   logic              rx_stb;
   logic              rx_synced;
   logic              rx_take;
   logic              rx_rd;
   logic              rx_clear;
   logic              tx_empty;
   logic              tx_load;
   logic              tx_src;
   logic              tx_req;
   logic              rx_req;
   logic              st_req;
   logic [1:0]        drain;
   sslink_pkg::tx_state_e tx_state;

   // ***************************************************
   // Pin synchronisers and line clock edges
   // ***************************************************
   assign pin_raw = {ring_i, carrier_i, cts_i, rxd_i, line_clk_i};

   // Two flops per pin, a third only for edge detection of the clean level
   generate
      for (genvar g = 0; g < NPIN; g++) begin : g_pin
         always_ff @(posedge core_clk_i or posedge rst_i) begin
            if (rst_i) begin
               pin_m[g] <= 1'b0;
               pin_s[g] <= 1'b0;
               pin_q[g] <= 1'b0;
            end else begin
               pin_m[g] <= pin_raw[g];
               pin_s[g] <= pin_m[g];
               pin_q[g] <= pin_s[g];
            end
         end
      end
   endgenerate

   // Sampling at 100 MHz leaves ample margin at the top line rate
   assign rx_en     = pin_s[0] & ~pin_q[0];
   assign tx_en     = ~pin_s[0] & pin_q[0];
   assign cts_s     = pin_s[2];
   assign car_chg   = pin_s[3] ^ pin_q[3];
   assign ring_rise = pin_s[4] & ~pin_q[4];

   // ***************************************************
   // Wishbone slave
   // ***************************************************
   assign wb_req = wb_cyc_i & wb_stb_i;
   assign wr     = wb_req & wb_ack_o & wb_we_i;
   assign rd     = wb_req & wb_ack_o & ~wb_we_i;
   assign wmask  = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   assign wd     = wb_dat_i[15:0] & wmask;
   assign rx_rd  = rd & (wb_adr_i == sslink_pkg::ADDR_RXD);

   // Read mux; unmapped offsets read as zero and ignore writes
   always_comb begin
      rdata = '0;
      case (wb_adr_i)
         sslink_pkg::ADDR_CTRL: rdata[sslink_pkg::CTRL_W-1:0] = ctrl;
         sslink_pkg::ADDR_SYNC: rdata[W-1:0] = sync_chr;
         sslink_pkg::ADDR_TXD: begin
            rdata[W-1:0] = tx_hold;
            rdata[sslink_pkg::BUF_FULL] = hold_full;
         end
         sslink_pkg::ADDR_RXD: begin
            rdata[W-1:0] = rx_hold;
            rdata[sslink_pkg::BUF_FULL] = rx_full;
         end
         sslink_pkg::ADDR_ST: begin
            rdata[sslink_pkg::NUM_EV-1:0] = st;
            rdata[sslink_pkg::ST_RSYNC] = rx_synced;
            rdata[sslink_pkg::ST_CARL]  = pin_s[3];
            rdata[sslink_pkg::ST_CTS]   = cts_s;
            rdata[sslink_pkg::ST_RTS]   = rts_o;
         end
         sslink_pkg::ADDR_MASK: rdata[sslink_pkg::NUM_EV-1:0] = mask;
         default: rdata = '0;
      endcase
   end

   // One wait state: data and ack rise together, ack drops the cycle after
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         wb_ack_o <= wb_req & ~wb_ack_o;
         if (wb_req & ~wb_ack_o) begin
            wb_dat_o <= rdata;
         end
      end
   end

   // ***************************************************
   // Control, sync and mask registers
   // ***************************************************
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ctrl     <= sslink_pkg::CTRL_RST;
         sync_chr <= '0;
         mask     <= '0;
      end else if (wr) begin
         if (wb_adr_i == sslink_pkg::ADDR_CTRL) begin
            ctrl <= (ctrl & ~wmask[sslink_pkg::CTRL_W-1:0]) | wd[sslink_pkg::CTRL_W-1:0];
         end
         if (wb_adr_i == sslink_pkg::ADDR_SYNC) begin
            sync_chr <= (sync_chr & ~wmask[W-1:0]) | wd[W-1:0];
         end
         if (wb_adr_i == sslink_pkg::ADDR_MASK) begin
            mask <= (mask & ~wmask[sslink_pkg::NUM_EV-1:0]) | wd[sslink_pkg::NUM_EV-1:0];
         end
      end
   end

   // Long codes fall back to 8 bits unless the wide option is built in
   assign len    = sslink_pkg::char_len(ctrl[sslink_pkg::CTRL_LEN+:3], EXT_LEN);
   assign sync_m = sync_chr & (sslink_pkg::ALL_ONES >> (4'hC - len));
   assign dtr_o  = ctrl[sslink_pkg::CTRL_DTR];

   // ***************************************************
   // Receive path
   // ***************************************************
   // Half duplex: our own send request blanks the receiver to avoid echo
   assign rx_clear = ~ctrl[sslink_pkg::CTRL_RXEN] | (ctrl[sslink_pkg::CTRL_HDX] & rts_o);

   sync_rx_deserializer #(
      .W (W)
   ) u_rx (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .clear_i    (rx_clear),
      .bit_en_i   (rx_en),
      .line_i     (pin_s[1]),
      .len_i      (len),
      .sync_i     (sync_chr),
      .char_o     (rx_char),
      .stb_o      (rx_stb),
      .synced_o   (rx_synced)
   );

   // Sync characters are dropped here when removal is on
   assign rx_take = rx_stb & ~(ctrl[sslink_pkg::CTRL_STRIP] & (rx_char == sync_m));

   // Holding register behind the shifter; a new character beats a read
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rx_hold <= '0;
         rx_full <= 1'b0;
      end else if (rx_take) begin
         rx_hold <= rx_char;
         rx_full <= 1'b1;
      end else if (rx_rd) begin
         rx_full <= 1'b0;
      end
   end

   // ***************************************************
   // Transmit path
   // ***************************************************
   assign tx_src  = hold_full | ctrl[sslink_pkg::CTRL_IDLE];
   assign tx_word = hold_full ? tx_hold : sync_chr;
   assign tx_load = tx_en & tx_empty & (((tx_state == sslink_pkg::TX_WAIT) & cts_s & tx_src)
                                        | ((tx_state == sslink_pkg::TX_RUN) & tx_src)
                                        | ((tx_state == sslink_pkg::TX_DRAIN) & hold_full));

   // Holding register; a write in the load cycle keeps the new word pending
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         tx_hold   <= '0;
         hold_full <= 1'b0;
      end else if (wr && wb_adr_i == sslink_pkg::ADDR_TXD) begin
         tx_hold   <= (tx_hold & ~wmask[W-1:0]) | wd[W-1:0];
         hold_full <= 1'b1;
      end else if (tx_load & hold_full) begin
         hold_full <= 1'b0;
      end
   end

   // Send request sequencing; data starts only after clear to send
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         tx_state <= sslink_pkg::TX_OFF;
         rts_o    <= 1'b0;
         drain    <= 2'h0;
      end else if (tx_en) begin
         case (tx_state)
            sslink_pkg::TX_OFF: begin
               if (hold_full) begin
                  rts_o    <= 1'b1;
                  tx_state <= sslink_pkg::TX_WAIT;
               end
            end
            sslink_pkg::TX_WAIT: begin
               if (cts_s) begin
                  tx_state <= sslink_pkg::TX_RUN;
               end
            end
            sslink_pkg::TX_RUN: begin
               drain <= 2'h0;
               if (tx_empty & ~tx_src) begin
                  tx_state <= sslink_pkg::TX_DRAIN;
               end
            end
            sslink_pkg::TX_DRAIN: begin
               if (hold_full) begin
                  tx_state <= sslink_pkg::TX_RUN;
               end else if (drain == sslink_pkg::RTS_DROP_EDGES - 2'h1) begin
                  rts_o    <= 1'b0;
                  tx_state <= sslink_pkg::TX_OFF;
               end else begin
                  drain <= drain + 2'h1;
               end
            end
            default: tx_state <= sslink_pkg::TX_OFF;
         endcase
      end
   end

   sync_tx_serializer #(
      .W (W)
   ) u_tx (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .bit_en_i   (tx_en),
      .load_i     (tx_load),
      .data_i     (tx_word),
      .len_i      (len),
      .line_o     (txd_o),
      .empty_o    (tx_empty)
   );

   // ***************************************************
   // Status and interrupts
   // ***************************************************
   // Idle sync sends raise no transmit event, only real data does
   always_comb begin
      ev = '0;
      ev[sslink_pkg::ST_RX]   = rx_take;
      ev[sslink_pkg::ST_TX]   = tx_load & hold_full;
      ev[sslink_pkg::ST_CAR]  = car_chg;
      ev[sslink_pkg::ST_OVR]  = rx_take & rx_full & ~rx_rd;
      ev[sslink_pkg::ST_RING] = ring_rise;
      clr = (wr && wb_adr_i == sslink_pkg::ADDR_ST) ? wd[sslink_pkg::NUM_EV-1:0] : '0;
   end

   // Sticky bits, write one to clear; a new event wins over the clear
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         st <= '0;
      end else begin
         st <= (st & ~clr) | ev;
      end
   end

   // Priority is fixed by wiring these to separate request lines
   assign st_req = ctrl[sslink_pkg::CTRL_STIE] & (|(st[4:2] & mask[4:2]));
   assign tx_req = (ctrl[sslink_pkg::CTRL_TXIE] & st[sslink_pkg::ST_TX] & mask[sslink_pkg::ST_TX]) | st_req;
   assign rx_req = ctrl[sslink_pkg::CTRL_RXIE] & st[sslink_pkg::ST_RX] & mask[sslink_pkg::ST_RX];

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         tx_irq_o <= 1'b0;
         rx_irq_o <= 1'b0;
         irq_o    <= 1'b0;
      end else begin
         tx_irq_o <= tx_req;
         rx_irq_o <= rx_req;
         irq_o    <= tx_req | rx_req;
      end
   end

   // ***************************************************
   // Checks
   // ***************************************************
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);

   sequence s_ring_seen;
      ring_rise && ctrl[sslink_pkg::CTRL_STIE] && mask[sslink_pkg::ST_RING];
   endsequence

   chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held more than one cycle");
   chk_ring_irq: assert property (s_ring_seen ##1 ctrl[sslink_pkg::CTRL_STIE] |=> tx_irq_o)
      else $error("ring did not raise status request");
   chk_no_status_irq: assert property (!st_req && !ctrl[sslink_pkg::CTRL_TXIE] |=> !tx_irq_o)
      else $error("transmit request without enable");
   chk_overrun_set: assert property (rx_take && rx_full && !rx_rd |=> st[sslink_pkg::ST_OVR])
      else $error("overrun not flagged");
   chk_idle_sync: assert property (tx_load && !hold_full |=> txd_o == $past(sync_chr[0]))
      else $error("idle fill not from sync register");
   chk_tx_event: assert property (tx_load && hold_full |=> st[sslink_pkg::ST_TX] && !$past(rts_o) == 1'b0)
      else $error("data load raised no transmit event");
   chk_rts_off_mark: assert property ($fell(rts_o) |-> tx_state == sslink_pkg::TX_OFF && txd_o)
      else $error("send request dropped with line not at mark");
   chk_hdx_inhibit: assert property (ctrl[sslink_pkg::CTRL_HDX] && rts_o |=> !rx_synced)
      else $error("receiver active during half duplex send");

endmodule

// *** verification/modem_model.sv ***
// Behavioural synchronous modem on the far side of the line
`timescale 1ns/1ps
module modem_model (
   input  wire logic run_i,
   input  wire logic rts_i,
   input  wire logic dtr_i,
   input  wire logic txd_i,
   input  wire logic ring_req_i,
   output logic      line_clk_o,
   output logic      cts_o,
   output logic      carrier_o,
   output logic      ring_o,
   output logic      rxd_o
);
   // Line clock stands low outside frames, 160 ns period inside
   initial line_clk_o = 1'b0;
   always #80 line_clk_o = run_i ? ~line_clk_o : 1'b0;
   // Carrier follows terminal ready once the call is answered
   initial carrier_o = 1'b0;
   always @(dtr_i) carrier_o <= #500 dtr_i;
   assign cts_o  = rts_i & carrier_o;
   assign ring_o = ring_req_i & ~dtr_i; // Ringing stops once answered
   assign rxd_o  = txd_i; // Loopback lets one line carry both directions
endmodule

// *** verification/tb_top.sv ***
// Self-checking testbench of the synchronous serial line interface
`timescale 1ns/1ps
module tb_top;
   logic clk, rst, cyc, stb, we, run, ring_req, ack;
   logic [3:0] sel;
   logic [7:0] adr;
   logic [31:0] dat, rdat, q;
   logic txd, rts, dtr, rxi, txi, irq, lclk, cts, car, ring, rxd;
   int failures = 0;
   int comparisons = 0;
   // ***************************************************
   // Clock, reset and instances
   // ***************************************************
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   sync_serial_line_interface dut (.core_clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .line_clk_i(lclk),
      .rxd_i(rxd), .cts_i(cts), .carrier_i(car), .ring_i(ring), .txd_o(txd), .rts_o(rts), .dtr_o(dtr),
      .rx_irq_o(rxi), .tx_irq_o(txi), .irq_o(irq));
   modem_model modem (.run_i(run), .rts_i(rts), .dtr_i(dtr), .txd_i(txd), .ring_req_i(ring_req),
      .line_clk_o(lclk), .cts_o(cts), .carrier_o(car), .ring_o(ring), .rxd_o(rxd));
   // ***************************************************
   // Shared tasks
   // ***************************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Classic single cycle; holds the request until ack is sampled
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= 4'hF;
      do @(posedge clk); while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0; stb <= 1'b0;
      @(posedge clk);
   endtask
   // Poll a status bit with a bounded number of reads
   task automatic poll(input int b);
      for (int i = 0; i < 600; i++) begin
         wb(1'b0, sslink_pkg::ADDR_ST, 32'h0000_0000);
         if (q[b] === 1'b1) break;
      end
   endtask
   task automatic final_report();
      $display("failures %0d comparisons %0d", failures, comparisons);
      if (failures == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // ***************************************************
   // Scenarios
   // ***************************************************
   task automatic t_reset();
      wb(1'b0, sslink_pkg::ADDR_CTRL, 32'h0000_0000);
      chk(q, 32'h0000_0000);
      chk({rts, dtr, txd, irq}, 32'h0000_0002);
      $display("reset test done");
   endtask
   task automatic t_ring();
      wb(1'b1, sslink_pkg::ADDR_MASK, 32'h0000_001F);
      wb(1'b1, sslink_pkg::ADDR_CTRL, 32'h0000_0004);
      @(posedge clk) ring_req <= 1'b1;
      poll(sslink_pkg::ST_RING);
      chk(q[4], 1'b1);
      chk({txi, irq, rxi}, 32'h0000_0006);
      wb(1'b1, sslink_pkg::ADDR_CTRL, 32'h0000_0044); // Answer the call
      ring_req <= 1'b0;
      chk(dtr, 1'b1);
      poll(sslink_pkg::ST_CAR);
      chk(q[9:8], 2'h2);
      wb(1'b1, sslink_pkg::ADDR_ST, 32'h0000_001F);
      repeat (3) @(posedge clk);
      chk(txi, 1'b0);
      $display("ring test done");
   endtask
   task automatic t_line();
      run <= 1'b1;
      wb(1'b1, sslink_pkg::ADDR_SYNC, 32'h0000_0016);
      wb(1'b1, sslink_pkg::ADDR_CTRL, 32'h0000_01D9); // 7 bits, receive, idle fill, removal, rx irq
      wb(1'b1, sslink_pkg::ADDR_TXD, 32'h0000_0016);
      poll(sslink_pkg::ST_RSYNC);
      chk(q[8], 1'b1);
      chk(rts, 1'b1);
      wb(1'b1, sslink_pkg::ADDR_TXD, 32'h0000_005A);
      poll(sslink_pkg::ST_RX);
      chk(q[1:0], 2'h3); // Transmit and receive events both flagged
      chk({txi, rxi}, 2'h1); // Receive request raised on its own
      wb(1'b0, sslink_pkg::ADDR_RXD, 32'h0000_0000);
      chk(q[11:0], 12'h05A); // 7-bit character, idle sync removed
      wb(1'b1, sslink_pkg::ADDR_CTRL, 32'h0000_01D0); // Keep syncs, never read them
      repeat (600) @(posedge clk);
      wb(1'b0, sslink_pkg::ADDR_ST, 32'h0000_0000);
      chk(q[3], 1'b1);
      wb(1'b1, sslink_pkg::ADDR_CTRL, 32'h0000_01F0); // Half duplex while still sending
      wb(1'b0, sslink_pkg::ADDR_ST, 32'h0000_0000);
      chk(q[8], 1'b0); // Own send request blanks the receiver
      wb(1'b1, sslink_pkg::ADDR_CTRL, 32'h0000_01C0);
      for (int i = 0; i < 2000 && rts !== 1'b0; i++) @(posedge clk);
      chk({rts, txd}, 2'h1); // Line back at mark, send request off
      run <= 1'b0;
      $display("line test done");
   endtask
   // ***************************************************
   // Main sequence and watchdog
   // ***************************************************
   initial begin
      rst = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; dat = 32'h0000_0000;
      run = 1'b0; ring_req = 1'b0; sel = 4'h0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_ring();
      t_line();
      final_report();
   end
   // Bound of 90,000 cycles: many times the expected run, under the cycle budget
   initial begin
      #900000;
      failures++;
      final_report();
   end
endmodule
